/* File: hdl/hpms_pkg.sv */
// hpms_pkg: constants and carriers for the poll setup register bank
package hpms_pkg;
	// register addresses
	localparam logic [15:0] ADDR_PRESET = 16'h0304;
	localparam logic [15:0] ADDR_POLL = 16'h0305;
	localparam logic [15:0] ADDR_MAP = 16'h0306;
	localparam logic [15:0] ADDR_PORT = 16'h0307;
	localparam logic [15:0] ADDR_REV = 16'h0308;
	localparam logic [15:0] ADDR_STATE = 16'h0309;
	// poll settings fields
	localparam int POLL_IVL_LSB = 13;
	localparam int POLL_LOCK_BIT = 12;
	localparam int POLL_LOWV_BIT = 11;
	localparam int POLL_FAIL_LSB = 8;
	localparam int POLL_RETRY_LSB = 6;
	localparam int POLL_MODEM_BIT = 5;
	localparam int POLL_PRIM_BIT = 4;
	localparam int POLL_NDEV_LSB = 0;
	localparam logic [15:0] POLL_WR_MASK = 16'hF3FF;
	// map and order fields
	localparam int MAP_TYPE_LSB = 10;
	localparam int MAP_SWAP_BIT = 9;
	localparam int MAP_VAR_BIT = 8;
	localparam logic [15:0] MAP_WR_MASK = 16'h0300;
	// port fields
	localparam int PORT_232_BIT = 14;
	localparam int PORT_PAR_LSB = 12;
	localparam int PORT_BAUD_LSB = 8;
	localparam logic [15:0] PORT_WR_MASK = 16'h7FFF;
	// reset values, used until the nonvolatile image is restored
	localparam logic [15:0] PRESET_RST = 16'h0000;
	localparam logic [15:0] POLL_RST = 16'h2040;
	localparam logic [15:0] MAP_RST = 16'h0000;
	localparam logic [15:0] PORT_RST = 16'h0901;
	// arbitrary neutral identity values
	localparam logic [3:0] TYPE_CODE = 4'h0;
	localparam logic [15:0] REV_CODE = 16'h0000;
	// function and exception codes
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WR1 = 8'h06;
	localparam logic [7:0] FN_WRN = 8'h10;
	localparam logic [7:0] EX_NONE = 8'h00;
	localparam logic [7:0] EX_FUNC = 8'h01;
	localparam logic [7:0] EX_ADDR = 8'h02;
	localparam logic [7:0] EX_LOCK = 8'h04;
	localparam logic [7:0] SLAVE_MAX = 8'hF7;
	localparam logic [7:0] HART_CMD_VARS = 8'h03;
	localparam int HART_BAUD = 1200;
	// failed fill modes and values
	localparam logic [1:0] FAIL_HOLD = 2'h0;
	localparam logic [1:0] FAIL_PRESET = 2'h1;
	localparam logic [1:0] FAIL_NAN = 2'h2;
	localparam logic [31:0] FLOAT_NAN = 32'h7FC00000;
	// clock and timing
	localparam int CLK_HZ = 25000000;
	localparam int SEC_NS = 1000000000;
	localparam int CLK_NS = SEC_NS / CLK_HZ;
	localparam int TICKS_PER_SEC = SEC_NS / CLK_NS;
	typedef struct packed {
		logic valid;
		logic [7:0] slave;
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] data;
	} hpms_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] func;
		logic [7:0] exc;
		logic [15:0] data;
	} hpms_resp_t;
	typedef struct packed {
		logic valid;
		logic [3:0] dev;
		logic [15:0] int_val;
		logic [15:0] w0;
		logic [15:0] w1;
	} hpms_fill_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_POLL = 2'b01,
		ST_WAIT = 2'b10,
		ST_NEXT = 2'b11
	} hpms_state_t;
endpackage

/* File: hdl/hpms_regs.sv */
// hpms_regs: setup register bank and poll sequencer of the field-device poll modem
// Operation
// - floats go out as two words, MSB first
// - map bit 9 swaps the two float words
// - failed field selects hold, preset or NaN fill
// - retry field sets zero to three re-polls
// - functions 6 and 16 write setup registers
// - written settings are kept in nonvolatile storage
// - interval code selects 1,2,5,10,20,60 seconds
// - write-lock bit makes settings read only
// - low-supply bit set below six volts
// - mode bit 5 selects fill or pass-through
// - bit 4 selects primary or secondary master
// - four-bit field holds polled devices minus one
// - map bit groups per device or per variable
// - port bit 14 selects RS-485 or RS-232
// - parity field none, even or odd
// - fill mode polls with command 3 each interval
// - pass-through runs the loop at 1200 odd
// - answers only its slave address, which master writes keep within 1 to 247
`timescale 1ns/1ns
`default_nettype none
module hpms_regs #(
	parameter int TICKS_SEC = hpms_pkg::TICKS_PER_SEC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire hpms_pkg::hpms_req_t req,
	output hpms_pkg::hpms_resp_t resp,
	input wire logic nv_load_valid,
	input wire logic [1:0] nv_load_sel,
	input wire logic [15:0] nv_load_data,
	output logic nv_wr,
	output logic [1:0] nv_wr_sel,
	output logic [15:0] nv_wr_data,
	input wire logic supply_low,
	output logic poll_req,
	output logic [3:0] poll_dev,
	output logic [7:0] poll_cmd,
	input wire logic poll_done,
	input wire logic poll_ok,
	input wire logic var_valid,
	input wire logic [31:0] var_float,
	output logic var_wvalid,
	output logic [15:0] var_w0,
	output logic [15:0] var_w1,
	output hpms_pkg::hpms_fill_t fill,
	output logic modem_mode,
	output logic primary_master,
	output logic map_by_var,
	output logic port_rs232,
	output logic [1:0] port_parity,
	output logic [3:0] port_baud,
	output logic [7:0] slave_addr
);
	import hpms_pkg::*;

	logic [15:0] preset_reg;
	logic [15:0] poll_reg;
	logic [15:0] map_reg;
	logic [15:0] port_reg;
	logic [15:0] state_reg;
	logic lowv_reg;
	logic [15:0] rd_data;
	logic addr_ok;
	logic is_wr;
	logic for_me;
	logic lock_ok;
	logic wr_go;
	logic poll_wr;
	hpms_state_t st_reg;
	logic [31:0] tick_reg;
	logic [5:0] sec_reg;
	logic [5:0] ivl_secs;
	logic [3:0] dev_reg;
	logic [1:0] try_reg;

	// float words: AB first unless the swap bit is set
	function automatic logic [31:0] order_words(input logic [31:0] f, input logic swap);
		order_words = swap ? {f[15:0], f[31:16]} : f;
	endfunction

	// interval code to seconds; 0 and 7 leave polling stopped
	always_comb begin
		case (poll_reg[POLL_IVL_LSB +: 3])
			3'h1: ivl_secs = 6'd1;
			3'h2: ivl_secs = 6'd2;
			3'h3: ivl_secs = 6'd5;
			3'h4: ivl_secs = 6'd10;
			3'h5: ivl_secs = 6'd20;
			3'h6: ivl_secs = 6'd60;
			default: ivl_secs = 6'd0;
		endcase
	end

	// request decode; broadcast slave 0 is taken for writes only
	assign is_wr = (req.func == FN_WR1) || (req.func == FN_WRN);
	assign for_me = (req.slave == slave_addr) || (is_wr && req.slave == 8'h00);
	assign addr_ok = (req.addr >= ADDR_PRESET) && (req.addr <= ADDR_STATE);
	// a locked bank only takes the one write that clears the lock
	assign lock_ok = !poll_reg[POLL_LOCK_BIT] ||
		(req.addr == ADDR_POLL && !req.data[POLL_LOCK_BIT]);
	assign wr_go = req.valid && for_me && is_wr && addr_ok && lock_ok &&
		req.addr != ADDR_REV && req.addr != ADDR_STATE;
	// poll settings change by master write or by image restore
	assign poll_wr = (wr_go && req.addr == ADDR_POLL) || (nv_load_valid && nv_load_sel == 2'd1);

	// read mux
	always_comb begin
		case (req.addr)
			ADDR_PRESET: rd_data = preset_reg;
			ADDR_POLL: rd_data = {poll_reg[15:12], lowv_reg, poll_reg[10:0]};
			ADDR_MAP: rd_data = {2'b00, TYPE_CODE, map_reg[9:0]};
			ADDR_PORT: rd_data = port_reg;
			ADDR_REV: rd_data = REV_CODE;
			ADDR_STATE: rd_data = state_reg;
			default: rd_data = 16'h0000;
		endcase
	end

	// answer one cycle after the request; the serial framer builds the reply
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			resp <= '0;
		end else begin
			resp.valid <= req.valid && for_me && req.slave != 8'h00;
			resp.func <= req.func;
			resp.data <= is_wr ? req.data : rd_data;
			if (req.func != FN_READ && !is_wr) begin
				resp.exc <= EX_FUNC;
			end else if (!addr_ok) begin
				resp.exc <= EX_ADDR;
			end else if (is_wr && !lock_ok) begin
				resp.exc <= EX_LOCK;
			end else if (is_wr && (req.addr == ADDR_REV || req.addr == ADDR_STATE)) begin
				resp.exc <= EX_ADDR;
			end else begin
				resp.exc <= EX_NONE;
			end
		end
	end

	// settings storage: restored from nonvolatile image, then written by the master
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			preset_reg <= PRESET_RST;
			poll_reg <= POLL_RST;
			map_reg <= MAP_RST;
			port_reg <= PORT_RST;
		end else if (nv_load_valid) begin
			case (nv_load_sel)
				2'd0: preset_reg <= nv_load_data;
				2'd1: poll_reg <= nv_load_data & POLL_WR_MASK;
				2'd2: map_reg <= nv_load_data & MAP_WR_MASK;
				default: port_reg <= nv_load_data & PORT_WR_MASK;
			endcase
		end else if (wr_go) begin
			case (req.addr)
				ADDR_PRESET: preset_reg <= req.data;
				ADDR_POLL: poll_reg <= req.data & POLL_WR_MASK;
				ADDR_MAP: map_reg <= req.data & MAP_WR_MASK;
				default: begin
					// out of range slave numbers keep the old address
					if (req.data[7:0] != 8'h00 && req.data[7:0] <= SLAVE_MAX) begin
						port_reg <= req.data & PORT_WR_MASK;
					end else begin
						port_reg <= {1'b0, req.data[14:8], port_reg[7:0]};
					end
				end
			endcase
		end
	end

	// every accepted write outside an image restore cycle is mirrored to the nonvolatile store
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			nv_wr <= 1'b0;
			nv_wr_sel <= 2'd0;
			nv_wr_data <= 16'h0000;
		end else begin
			nv_wr <= wr_go && !nv_load_valid;
			nv_wr_sel <= req.addr[1:0] - 2'd0;
			nv_wr_data <= req.data;
		end
	end

	// supply monitor level, sampled each clock
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lowv_reg <= 1'b0;
		end else begin
			lowv_reg <= supply_low;
		end
	end

	// decoded settings for the rest of the modem
	assign modem_mode = poll_reg[POLL_MODEM_BIT];
	assign primary_master = poll_reg[POLL_PRIM_BIT];
	assign map_by_var = map_reg[MAP_VAR_BIT];
	assign port_rs232 = port_reg[PORT_232_BIT];
	assign port_parity = port_reg[PORT_PAR_LSB +: 2];
	assign port_baud = port_reg[PORT_BAUD_LSB +: 4];
	assign slave_addr = port_reg[7:0];

	// second tick and interval count
	always_ff @(posedge clock) begin
		if (sys_rst || modem_mode) begin
			tick_reg <= 32'd0;
			sec_reg <= 6'd0;
		end else if (tick_reg == 32'(TICKS_SEC - 1)) begin
			tick_reg <= 32'd0;
			if (st_reg == ST_IDLE && sec_reg + 6'd1 >= ivl_secs) begin
				sec_reg <= 6'd0;
			end else if (sec_reg != 6'd63) begin
				sec_reg <= sec_reg + 6'd1;
			end
		end else begin
			tick_reg <= tick_reg + 32'd1;
		end
	end

	// poll sequencer; pass-through mode parks it
	// a poll settings change ends the round, so device and retry counts never outrun new limits
	always_ff @(posedge clock) begin
		if (sys_rst || modem_mode || poll_wr) begin
			st_reg <= ST_IDLE;
			dev_reg <= 4'h0;
			try_reg <= 2'd0;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					// a round starts once per interval
					if (ivl_secs != 6'd0 && tick_reg == 32'(TICKS_SEC - 1) &&
						sec_reg + 6'd1 >= ivl_secs) begin
						st_reg <= ST_POLL;
						dev_reg <= 4'h0;
						try_reg <= 2'd0;
					end
				end
				ST_POLL: st_reg <= ST_WAIT;
				ST_WAIT: begin
					if (poll_done) begin
						if (!poll_ok && try_reg < poll_reg[POLL_RETRY_LSB +: 2]) begin
							try_reg <= try_reg + 2'd1;
							st_reg <= ST_POLL;
						end else begin
							st_reg <= ST_NEXT;
						end
					end
				end
				ST_NEXT: begin
					try_reg <= 2'd0;
					if (dev_reg == poll_reg[POLL_NDEV_LSB +: 4]) begin
						st_reg <= ST_IDLE;
					end else begin
						dev_reg <= dev_reg + 4'h1;
						st_reg <= ST_POLL;
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	assign poll_req = st_reg == ST_POLL;
	assign poll_dev = dev_reg;
	assign poll_cmd = HART_CMD_VARS;

	// per-device failed flags, set and cleared by the poll outcome
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= 16'h0000;
		end else if (st_reg == ST_WAIT && poll_done) begin
			if (poll_ok) begin
				state_reg[dev_reg] <= 1'b0;
			end else if (try_reg >= poll_reg[POLL_RETRY_LSB +: 2]) begin
				state_reg[dev_reg] <= 1'b1;
			end
		end
	end

	// failed fill; hold mode writes nothing so the last value stands
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fill <= '0;
		end else begin
			fill.valid <= st_reg == ST_WAIT && poll_done && !poll_ok &&
				try_reg >= poll_reg[POLL_RETRY_LSB +: 2] &&
				poll_reg[POLL_FAIL_LSB +: 2] != FAIL_HOLD;
			fill.dev <= dev_reg;
			if (poll_reg[POLL_FAIL_LSB +: 2] == FAIL_PRESET) begin
				fill.int_val <= preset_reg;
				{fill.w0, fill.w1} <= {16'h0000, preset_reg};
			end else begin
				fill.int_val <= 16'h0000;
				{fill.w0, fill.w1} <= order_words(FLOAT_NAN, map_reg[MAP_SWAP_BIT]);
			end
		end
	end

	// live float values laid out as two holding words
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			var_wvalid <= 1'b0;
			var_w0 <= 16'h0000;
			var_w1 <= 16'h0000;
		end else begin
			var_wvalid <= var_valid;
			{var_w0, var_w1} <= order_words(var_float, map_reg[MAP_SWAP_BIT]);
		end
	end

	word_order_a: assert property (@(posedge clock) disable iff (sys_rst)
		var_valid |=> var_wvalid && (map_reg[MAP_SWAP_BIT] || var_w0 == $past(var_float[31:16])))
		else $error("float high word not first");
	word_swap_a: assert property (@(posedge clock) disable iff (sys_rst)
		var_valid && map_reg[MAP_SWAP_BIT] && !wr_go |=> var_w0 == $past(var_float[15:0]))
		else $error("swapped order not applied");
	lock_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		req.valid && poll_reg[POLL_LOCK_BIT] && req.addr == ADDR_PORT && !nv_load_valid
		|=> $stable(port_reg))
		else $error("locked port settings changed");
	lock_exc_a: assert property (@(posedge clock) disable iff (sys_rst)
		req.valid && for_me && is_wr && addr_ok && !lock_ok && req.slave != 8'h00
		|=> resp.valid && resp.exc == EX_LOCK)
		else $error("locked write not refused");
	nv_mirror_a: assert property (@(posedge clock) disable iff (sys_rst)
		wr_go && !nv_load_valid |=> nv_wr && nv_wr_data == $past(req.data))
		else $error("write not mirrored to store");
	retry_bound_a: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg == ST_POLL |-> try_reg <= poll_reg[POLL_RETRY_LSB +: 2])
		else $error("too many retries");
	fail_fill_a: assert property (@(posedge clock) disable iff (sys_rst)
		fill.valid |-> state_reg[fill.dev] && poll_reg[POLL_FAIL_LSB +: 2] != FAIL_HOLD)
		else $error("fill without failed device");
	dev_count_a: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg == ST_POLL |-> dev_reg <= poll_reg[POLL_NDEV_LSB +: 4])
		else $error("polled beyond device count");
	modem_park_a: assert property (@(posedge clock) disable iff (sys_rst)
		modem_mode |=> !poll_req)
		else $error("polling in pass-through mode");
	lowv_a: assert property (@(posedge clock) disable iff (sys_rst)
		supply_low |=> lowv_reg ##0 (rd_data[POLL_LOWV_BIT] || req.addr != ADDR_POLL))
		else $error("low supply not shown");
	slave_a: assert property (@(posedge clock) disable iff (sys_rst)
		req.valid && req.slave != slave_addr |=> !resp.valid)
		else $error("answered foreign address");
endmodule
`default_nettype wire

/* File: verif/hpms_field_model.sv */
// hpms_field_model: field devices on the poll loop, one reply per poll attempt
`timescale 1ns/1ns
`default_nettype none
module hpms_field_model (
	input wire logic clock,
	input wire logic poll_req,
	input wire logic [3:0] poll_dev,
	input wire logic [15:0] fail_mask,
	output logic poll_done,
	output logic poll_ok
);
	int left = -1;
	logic slow = 1'b0;
	logic [3:0] dev_q = 4'h0;
	initial begin
		poll_done = 1'b0;
		poll_ok = 1'b0;
	end
	// prompt and slow replies alternate; ok toggles between replies so no stale level is seen
	always @(negedge clock) begin
		poll_done <= 1'b0;
		poll_ok <= ~poll_ok;
		if (poll_req === 1'b1) begin
			dev_q <= poll_dev;
			slow <= ~slow;
			left <= slow ? 6 : 1;
		end else if (left > 0) begin
			left <= left - 1;
		end else if (left == 0) begin
			left <= -1;
			poll_done <= 1'b1;
			poll_ok <= ~fail_mask[dev_q]; // a masked device answers with an error
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// tb: self-checking bench for the setup register bank and poll sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
	import hpms_pkg::*;
	localparam int TS = 10;
	logic clock, sys_rst, nv_load_valid, nv_wr, supply_low, poll_req, poll_done, poll_ok;
	logic var_valid, var_wvalid, modem_mode, primary_master, map_by_var, port_rs232;
	logic [1:0] nv_load_sel, nv_wr_sel, port_parity;
	logic [3:0] poll_dev, port_baud;
	logic [7:0] poll_cmd, slave_addr;
	logic [15:0] nv_load_data, nv_wr_data, var_w0, var_w1, fmask, sfail, pv;
	logic [31:0] var_float, vw, d;
	logic [17:0] nw_q;
	hpms_req_t req;
	hpms_resp_t resp, rsp_q;
	hpms_fill_t fill, fl_q, ef;
	logic [15:0] m [4];
	int secs [6] = '{1, 2, 5, 10, 20, 60};
	int error_cnt = 0;
	int num_checks = 0;
	int rsp_n = 0, nw_n = 0, fl_n = 0, att = 0, fl_att = 0;
	int np = 0, cyc = 0, lastp = 0, pp = 0, got = 0, k, j, n0;
	hpms_regs #(.TICKS_SEC(TS)) u_dut (.clock, .sys_rst, .req, .resp, .nv_load_valid,
		.nv_load_sel, .nv_load_data, .nv_wr, .nv_wr_sel, .nv_wr_data, .supply_low, .poll_req,
		.poll_dev, .poll_cmd, .poll_done, .poll_ok, .var_valid, .var_float, .var_wvalid,
		.var_w0, .var_w1, .fill, .modem_mode, .primary_master, .map_by_var, .port_rs232,
		.port_parity, .port_baud, .slave_addr);
	hpms_field_model u_field (.clock, .poll_req, .poll_dev, .fail_mask(fmask), .poll_done,
		.poll_ok);
	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// capture outputs just after each edge so pulses are never missed
	always @(posedge clock) begin
		#1;
		cyc++;
		if (resp.valid === 1'b1) begin
			rsp_q = resp;
			rsp_n++;
		end
		if (nv_wr === 1'b1) begin
			nw_n++;
			nw_q = {nv_wr_sel, nv_wr_data};
		end
		if (var_wvalid === 1'b1)
			vw = {var_w0, var_w1};
		if (poll_req === 1'b1 && poll_dev == 4'h1)
			att++;
		if (poll_req === 1'b1 && poll_dev == 4'h0) begin
			np++;
			pp = cyc - lastp;
			lastp = cyc;
		end
		if (fill.valid === 1'b1) begin
			fl_q = fill;
			fl_n++;
			fl_att = att;
			att = 0;
		end
	end
	task automatic chk_val(input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one request held for one edge, then two edges for the answer to land
	task automatic bus(input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] ad,
		input logic [15:0] dt);
		int c0;
		c0 = rsp_n;
		req = '{1'b1, sl, fn, ad, dt};
		@(negedge clock);
		req.valid = 1'b0;
		nv_load_valid = 1'b0;
		repeat (2) @(negedge clock);
		got = rsp_n - c0;
	endtask
	function automatic logic [15:0] rd(input int i);
		case (i)
			1: rd = m[1] | {4'h0, supply_low, 11'h000};
			2: rd = m[2] | {2'h0, TYPE_CODE, 10'h000};
			4: rd = REV_CODE;
			5: rd = sfail;
			default: rd = m[i];
		endcase
	endfunction
	task automatic wr(input int i, input logic [15:0] v);
		case (i)
			1: m[1] = v & POLL_WR_MASK;
			2: m[2] = v & MAP_WR_MASK;
			3: m[3] = (v[7:0] == 8'h00 || v[7:0] > SLAVE_MAX) ?
				{v[15:8], m[3][7:0]} & PORT_WR_MASK : v & PORT_WR_MASK;
			default: m[0] = v;
		endcase
	endtask
	// reference model of one access, then compare answer and store traffic
	task automatic acc(input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] dt);
		int i;
		int c0;
		logic [7:0] sl;
		hpms_resp_t e;
		i = int'(ad) - 772;
		c0 = nw_n;
		sl = m[3][7:0];
		e = '{1'b1, fn, EX_NONE, dt};
		if (fn != FN_READ && fn != FN_WR1 && fn != FN_WRN)
			e.exc = EX_FUNC;
		else if (i < 0 || i > 5)
			e.exc = EX_ADDR;
		else if (fn == FN_READ)
			e.data = rd(i);
		else if (i > 3)
			e.exc = EX_ADDR;
		else if (m[1][POLL_LOCK_BIT] && !(i == 1 && !dt[POLL_LOCK_BIT]))
			e.exc = EX_LOCK;
		else
			wr(i, dt);
		bus(sl, fn, ad, dt);
		chk_val(1, got);
		if (e.exc == EX_NONE)
			chk_val(e, rsp_q);
		else
			chk_val(e[32:16], rsp_q[32:16]);
		chk_val(e.exc == EX_NONE && fn != FN_READ, nw_n - c0);
		if (e.exc == EX_NONE && fn != FN_READ)
			chk_val({2'(i), dt}, nw_q);
	endtask
	// run is about 3000 cycles; cut a hang at 20000
	initial begin
		#800000;
		error_cnt++;
		complete_run;
	end
	initial begin
		sys_rst = 1'b1;
		req = '0;
		nv_load_valid = 1'b0;
		nv_load_sel = 2'h0;
		nv_load_data = 16'h0000;
		supply_low = 1'b0;
		var_valid = 1'b0;
		var_float = 32'h00000000;
		fmask = 16'h0000;
		sfail = 16'h0000;
		m = '{PRESET_RST, POLL_RST, MAP_RST, PORT_RST};
		void'($urandom(53));
		repeat (10) @(negedge clock);
		sys_rst = 1'b0;
		for (k = 0; k < 6; k++)
			acc(FN_READ, ADDR_PRESET + 16'(k), 16'h0000);
		supply_low = 1'b1;
		// the level is registered, so let one edge pass before reading it
		@(negedge clock);
		acc(FN_READ, ADDR_POLL, 16'h0000);
		supply_low = 1'b0;
		acc(8'h05, ADDR_PRESET, 16'h0001);
		acc(FN_WR1, 16'h030A, 16'h0001);
		acc(FN_WR1, ADDR_REV, 16'h0001);
		acc(FN_WRN, ADDR_STATE, 16'h0001);
		bus(8'h09, FN_READ, ADDR_PRESET, 16'h0000);
		chk_val(0, got);
		bus(8'h00, FN_WR1, ADDR_PRESET, 16'h1234);
		m[0] = 16'h1234;
		chk_val(0, got);
		acc(FN_READ, ADDR_PRESET, 16'h0000);
		$display("access test done");
		acc(FN_WR1, ADDR_PORT, 16'h5A07);
		for (k = 0; k < 3; k++) begin
			acc(FN_WRN, ADDR_PORT, 16'h09F8 | 16'(k << 12));
			chk_val(m[3][14:0], {port_rs232, port_parity, port_baud, slave_addr});
		end
		acc(FN_WR1, ADDR_POLL, 16'h3040);
		acc(FN_WR1, ADDR_PORT, 16'h1203);
		acc(FN_WR1, ADDR_PRESET, 16'h5555);
		acc(FN_WRN, ADDR_POLL, 16'h3050);
		acc(FN_WR1, ADDR_POLL, 16'h2050);
		acc(FN_READ, ADDR_PRESET, 16'h0000);
		chk_val({m[1][5], m[1][4]}, {modem_mode, primary_master});
		$display("port and lock test done");
		nv_load_valid = 1'b1;
		nv_load_data = 16'h0BAD;
		n0 = nw_n;
		bus(m[3][7:0], FN_WR1, ADDR_PRESET, 16'h1111);
		m[0] = 16'h0BAD;
		chk_val(n0, nw_n);
		acc(FN_READ, ADDR_PRESET, 16'h0000);
		for (k = 0; k < 8; k++) begin
			d = $urandom;
			acc(FN_WRN, ADDR_PRESET, d[15:0]);
			acc(FN_WR1, ADDR_MAP, d[31:16]);
			acc(FN_READ, ADDR_MAP, 16'h0000);
			acc(FN_READ, ADDR_PRESET, 16'h0000);
		end
		acc(FN_WR1, ADDR_MAP, 16'h0000);
		$display("store test done");
		acc(FN_WR1, ADDR_PRESET, 16'hABCD);
		fmask = 16'h0002;
		for (k = 0; k < 2; k++) begin
			pv = k ? 16'h22C1 : 16'h2141;
			acc(FN_WR1, ADDR_POLL, pv);
			n0 = fl_n;
			for (j = 0; j < 600 && fl_n == n0; j++)
				@(negedge clock);
			ef = '{1'b1, 4'h1, k ? 16'h0 : 16'hABCD, k ? 16'h7FC0 : 16'h0, k ? 16'h0 : 16'hABCD};
			chk_val(ef, fl_q);
			chk_val(int'(pv[7:6]) + 1, fl_att);
		end
		sfail = 16'h0002;
		acc(FN_READ, ADDR_STATE, 16'h0000);
		chk_val(HART_CMD_VARS, poll_cmd);
		fmask = 16'h0000;
		$display("fill test done");
		for (k = 0; k < 6; k++) begin
			acc(FN_WR1, ADDR_POLL, 16'(k + 1) << 13 | 16'h0040);
			n0 = np;
			for (j = 0; j < 2000 && np < n0 + 3; j++)
				@(negedge clock);
			chk_val(secs[k] * TS, pp);
		end
		acc(FN_WR1, ADDR_POLL, 16'h2020);
		repeat (20) @(negedge clock);
		n0 = np;
		repeat (60) @(negedge clock);
		chk_val(n0, np);
		chk_val(1'b1, modem_mode);
		$display("interval test done");
		for (k = 0; k < 2; k++) begin
			acc(FN_WR1, ADDR_MAP, 16'(k << 9) | 16'h0100);
			chk_val(1'b1, map_by_var);
			d = $urandom;
			var_float = d;
			var_valid = 1'b1;
			@(negedge clock);
			var_valid = 1'b0;
			@(negedge clock);
			chk_val(k ? {d[15:0], d[31:16]} : d, vw);
		end
		$display("word order test done");
		complete_run;
	end
endmodule
`default_nettype wire
